// >>> cis_core.sv
// core interrupt status and enable register with wishbone access
// assumes single clock, synchronous reset, vector pulses from the sequencer
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
// Function
// - 8-bit register index 07h: four flags in bits 7-4, enables in 3-0
// - peripheral flag is OR of peripheral flags ANDed with enables, read-only
// - clock-pin flag sets on selected edge of timer clock pin
// - clock-pin flag clears when execution vectors to 18h
// - timer flag sets on timer overflow, clears on vector 10h
// - irq-pin flag sets on selected edge, clears on vector 08h
// - peripheral enable gates the whole peripheral group at irq_req_o; event status and irq_o ignore it
// - global disable blocks every source at irq_req_o, not at irq_o; otherwise only enabled sources
module cis_core
	import cis_pkg::*;
#(
	parameter int NPERIPH = CIS_NPERIPH
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire cis_wb_req_t        wb_req_i,
	output logic                    wb_ack_o,
	output logic [31:0]             wb_dat_o,
	input  wire logic               timer_clock_input_pin_i,
	input  wire logic               external_irq_pin_i,
	input  wire logic               timer_overflow_i,
	input  wire logic [NPERIPH-1:0] periph_flags_i,
	input  wire logic [NPERIPH-1:0] periph_enables_i,
	input  wire logic               vec_take_i,
	input  wire logic [7:0]         vec_addr_i,
	output logic [CIS_NSRC-1:0]     irq_req_o,
	output logic                    irq_o
);

	logic                clkpin_edge;
	logic                irqpin_edge;
	logic                peripheral_pending_flag_nxt;
	logic                peripheral_pending_flag_r;
	logic                clk_flag_r;
	logic                tmr_flag_r;
	logic                irq_flag_r;
	logic [3:0]          en_r;
	logic [2:0]          ctrl_r;
	logic [CIS_NSRC-1:0] evt_r;
	logic [CIS_NSRC-1:0] mask_r;
	logic [CIS_NSRC-1:0] evt_set;
	logic [CIS_NSRC-1:0] req_nxt;
	logic                ack_r;
	logic [31:0]         dat_r;
	logic                bus_req;
	logic                wr_en;
	logic                wr_se;
	logic                wr_ctrl;
	logic                wr_evt;
	logic                wr_mask;
	logic [7:0]          wd;
	logic [7:0]          se_rd;
	logic                gdis;

	function automatic logic vec_hit(input logic take, input logic [7:0] a,
		input logic [7:0] v);
		vec_hit = take && (a == v);
	endfunction

	function automatic logic [31:0] zext8(input logic [7:0] b);
		zext8 = {24'h000000, b};
	endfunction

	cis_edge_det u_clkpin (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.pin_i    (timer_clock_input_pin_i),
		.rising_i (ctrl_r[CIS_CTRL_CLKEDG_BIT]),
		.edge_o   (clkpin_edge)
	);

	cis_edge_det u_irqpin (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.pin_i    (external_irq_pin_i),
		.rising_i (ctrl_r[CIS_CTRL_IRQEDG_BIT]),
		.edge_o   (irqpin_edge)
	);

	// bus decode; a write lands on the edge where the master sees ack
	assign bus_req = wb_req_i.cyc & wb_req_i.stb;
	assign wr_en   = bus_req & wb_req_i.we & ack_r & wb_req_i.sel[0];
	assign wr_se   = wr_en & (wb_req_i.adr == CIS_STATUS_ENABLE_ADR);
	assign wr_ctrl = wr_en & (wb_req_i.adr == CIS_CTRL_ADR);
	assign wr_evt  = wr_en & (wb_req_i.adr == CIS_EVT_STATUS_ADR);
	assign wr_mask = wr_en & (wb_req_i.adr == CIS_EVT_MASK_ADR);
	assign wd      = wb_req_i.dat[7:0];
	assign gdis    = ctrl_r[CIS_CTRL_GDIS_BIT];

	assign peripheral_pending_flag_nxt = |(periph_flags_i & periph_enables_i);

	assign se_rd = {peripheral_pending_flag_r, clk_flag_r, tmr_flag_r, irq_flag_r, en_r};

	// peripheral flag follows its sources, writes do not touch it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			peripheral_pending_flag_r <= 1'b0;
		end else begin
			peripheral_pending_flag_r <= peripheral_pending_flag_nxt;
		end
	end

	// clock-pin flag: hardware set beats vector and software clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_flag_r <= CIS_STATUS_ENABLE_RST[CIS_CLKPIN_FLAG_BIT];
		end else if (clkpin_edge) begin
			clk_flag_r <= 1'b1;
		end else if (vec_hit(vec_take_i, vec_addr_i, CIS_VEC_CLKPIN)) begin
			clk_flag_r <= 1'b0;
		end else if (wr_se) begin
			clk_flag_r <= wd[CIS_CLKPIN_FLAG_BIT];
		end
	end

	// timer overflow flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tmr_flag_r <= CIS_STATUS_ENABLE_RST[CIS_TIMER_FLAG_BIT];
		end else if (timer_overflow_i) begin
			tmr_flag_r <= 1'b1;
		end else if (vec_hit(vec_take_i, vec_addr_i, CIS_VEC_TIMER)) begin
			tmr_flag_r <= 1'b0;
		end else if (wr_se) begin
			tmr_flag_r <= wd[CIS_TIMER_FLAG_BIT];
		end
	end

	// interrupt pin flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_flag_r <= CIS_STATUS_ENABLE_RST[CIS_IRQPIN_FLAG_BIT];
		end else if (irqpin_edge) begin
			irq_flag_r <= 1'b1;
		end else if (vec_hit(vec_take_i, vec_addr_i, CIS_VEC_IRQPIN)) begin
			irq_flag_r <= 1'b0;
		end else if (wr_se) begin
			irq_flag_r <= wd[CIS_IRQPIN_FLAG_BIT];
		end
	end

	// enable nibble
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_r <= CIS_STATUS_ENABLE_RST[CIS_PERIPH_EN_BIT:CIS_IRQPIN_EN_BIT];
		end else if (wr_se) begin
			en_r <= wd[CIS_PERIPH_EN_BIT:CIS_IRQPIN_EN_BIT];
		end
	end

	// control: global disable comes up set so nothing fires before setup
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= CIS_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= wd[CIS_CTRL_IRQEDG_BIT:CIS_CTRL_GDIS_BIT];
		end
	end

	// requests to the sequencer
	always_comb begin
		req_nxt = '0;
		if (!gdis) begin
			req_nxt[CIS_SRC_IRQPIN] = irq_flag_r & en_r[CIS_IRQPIN_EN_BIT];
			req_nxt[CIS_SRC_TIMER]  = tmr_flag_r & en_r[CIS_TIMER_EN_BIT];
			req_nxt[CIS_SRC_CLKPIN] = clk_flag_r & en_r[CIS_CLKPIN_EN_BIT];
			req_nxt[CIS_SRC_PERIPH] = peripheral_pending_flag_r & en_r[CIS_PERIPH_EN_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_req_o <= '0;
		end else begin
			irq_req_o <= req_nxt;
		end
	end

	// event status: a flag rising, set wins over write-one-to-clear
	assign evt_set[CIS_SRC_IRQPIN] = irqpin_edge;
	assign evt_set[CIS_SRC_TIMER]  = timer_overflow_i;
	assign evt_set[CIS_SRC_CLKPIN] = clkpin_edge;
	assign evt_set[CIS_SRC_PERIPH] = peripheral_pending_flag_nxt & ~peripheral_pending_flag_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_r <= '0;
		end else begin
			evt_r <= (evt_r & ~(wr_evt ? wd[CIS_NSRC-1:0] : '0)) | evt_set;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_r <= '0;
		end else if (wr_mask) begin
			mask_r <= wd[CIS_NSRC-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(evt_r & mask_r);
		end
	end

	// single wait state answer; unmapped reads return zero with ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req & ~ack_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= '0;
		end else if (bus_req && !ack_r) begin
			if (wb_req_i.adr == CIS_STATUS_ENABLE_ADR) begin
				dat_r <= zext8(se_rd);
			end else if (wb_req_i.adr == CIS_CTRL_ADR) begin
				dat_r <= zext8({5'h00, ctrl_r});
			end else if (wb_req_i.adr == CIS_EVT_STATUS_ADR) begin
				dat_r <= zext8({4'h0, evt_r});
			end else if (wb_req_i.adr == CIS_EVT_MASK_ADR) begin
				dat_r <= zext8({4'h0, mask_r});
			end else begin
				dat_r <= '0;
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// checks
	sequence s_se_read;
		bus_req && !wb_req_i.we && !ack_r && wb_req_i.adr == CIS_STATUS_ENABLE_ADR;
	endsequence

	sequence s_se_answer;
		##1 ack_r && dat_r[7:0] == $past(se_rd);
	endsequence

	property p_se_read;
		@(posedge clk_i) disable iff (rst_i)
		s_se_read |-> s_se_answer;
	endproperty
	a_se_read: assert property (p_se_read)
		else $error("status/enable read data wrong");

	property p_peripheral_pending_flag;
		@(posedge clk_i) disable iff (rst_i)
		##1 peripheral_pending_flag_r == $past(|(periph_flags_i & periph_enables_i));
	endproperty
	a_peripheral_pending_flag: assert property (p_peripheral_pending_flag)
		else $error("peripheral flag not or of enabled sources");

	property p_clk_set;
		@(posedge clk_i) disable iff (rst_i)
		clkpin_edge |=> clk_flag_r;
	endproperty
	a_clk_set: assert property (p_clk_set)
		else $error("clock-pin edge lost");

	property p_clk_clr;
		@(posedge clk_i) disable iff (rst_i)
		vec_take_i && vec_addr_i == CIS_VEC_CLKPIN && !clkpin_edge |=> !clk_flag_r;
	endproperty
	a_clk_clr: assert property (p_clk_clr)
		else $error("clock-pin flag not cleared by vector");

	property p_tmr;
		@(posedge clk_i) disable iff (rst_i)
		(timer_overflow_i |=> tmr_flag_r) and
		(vec_take_i && vec_addr_i == CIS_VEC_TIMER && !timer_overflow_i |=> !tmr_flag_r);
	endproperty
	a_tmr: assert property (p_tmr)
		else $error("timer flag set or clear wrong");

	property p_irqpin;
		@(posedge clk_i) disable iff (rst_i)
		(irqpin_edge |=> irq_flag_r) and
		(vec_take_i && vec_addr_i == CIS_VEC_IRQPIN && !irqpin_edge |=> !irq_flag_r);
	endproperty
	a_irqpin: assert property (p_irqpin)
		else $error("irq-pin flag set or clear wrong");

	property p_group;
		@(posedge clk_i) disable iff (rst_i)
		!en_r[CIS_PERIPH_EN_BIT] |=> !irq_req_o[CIS_SRC_PERIPH];
	endproperty
	a_group: assert property (p_group)
		else $error("peripheral request despite group disable");

	property p_gdis;
		@(posedge clk_i) disable iff (rst_i)
		gdis |=> irq_req_o == '0;
	endproperty
	a_gdis: assert property (p_gdis)
		else $error("request while globally disabled");

	property p_direct;
		@(posedge clk_i) disable iff (rst_i)
		!gdis && tmr_flag_r && en_r[CIS_TIMER_EN_BIT] |=> irq_req_o[CIS_SRC_TIMER];
	endproperty
	a_direct: assert property (p_direct)
		else $error("timer request missing");

	property p_irq_out;
		@(posedge clk_i) disable iff (rst_i)
		##1 irq_o == $past(|(evt_r & mask_r));
	endproperty
	a_irq_out: assert property (p_irq_out)
		else $error("interrupt output mismatch");

endmodule // cis_core
`default_nettype wire

// >>> cis_pkg.sv
// package of the core interrupt status and enable block
// assumes a 32-bit classic wishbone master with byte addresses
package cis_pkg;

	// wishbone request, driven by the bus master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} cis_wb_req_t;

	// register index 07h; its byte address is four times it
	localparam logic [7:0] CIS_STATUS_ENABLE_IDX = 8'h07;
	localparam logic [7:0] CIS_STATUS_ENABLE_ADR = 8'h1c;
	localparam logic [7:0] CIS_CTRL_ADR          = 8'h00;
	localparam logic [7:0] CIS_EVT_STATUS_ADR    = 8'h04;
	localparam logic [7:0] CIS_EVT_MASK_ADR      = 8'h08;

	// status and enable register fields
	localparam int CIS_PERIPH_FLAG_BIT = 7;
	localparam int CIS_CLKPIN_FLAG_BIT = 6;
	localparam int CIS_TIMER_FLAG_BIT  = 5;
	localparam int CIS_IRQPIN_FLAG_BIT = 4;
	localparam int CIS_PERIPH_EN_BIT   = 3;
	localparam int CIS_CLKPIN_EN_BIT   = 2;
	localparam int CIS_TIMER_EN_BIT    = 1;
	localparam int CIS_IRQPIN_EN_BIT   = 0;
	localparam logic [7:0] CIS_STATUS_ENABLE_RST = 8'h00;

	// control register fields
	localparam int CIS_CTRL_GDIS_BIT   = 0;
	localparam int CIS_CTRL_CLKEDG_BIT = 1;
	localparam int CIS_CTRL_IRQEDG_BIT = 2;
	localparam logic [2:0] CIS_CTRL_RST = 3'h1;

	// source index shared by requests, event status and mask
	localparam int CIS_SRC_IRQPIN = 0;
	localparam int CIS_SRC_TIMER  = 1;
	localparam int CIS_SRC_CLKPIN = 2;
	localparam int CIS_SRC_PERIPH = 3;
	localparam int CIS_NSRC       = 4;

	// fixed vector addresses that clear the matching flag
	localparam logic [7:0] CIS_VEC_IRQPIN = 8'h08;
	localparam logic [7:0] CIS_VEC_TIMER  = 8'h10;
	localparam logic [7:0] CIS_VEC_CLKPIN = 8'h18;

	// peripheral group size
	localparam int CIS_NPERIPH = 16;

endpackage

// >>> cis_edge_det.sv
// synchronised edge detector for an asynchronous pin
// assumes the pin is outside the clk_i domain
`timescale 1ns/1ns
`default_nettype none
module cis_edge_det (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	input  wire logic rising_i,
	output logic      edge_o
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// meta_r is read by sync_r only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= pin_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// one-cycle pulse on the selected edge
	assign edge_o = rising_i ? (sync_r & ~prev_r) : (~sync_r & prev_r);

endmodule // cis_edge_det
`default_nettype wire

// >>> cis_seq_model.sv
// sequencer model: vectors to the fixed address of a pending direct source
// assumes go_i enables vectoring and dly_i is at least 2 cycles
`timescale 1ns/1ns
`default_nettype none
module cis_seq_model
	import cis_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       go_i,
	input  wire logic [3:0] dly_i,
	input  wire logic [3:0] irq_req_i,
	output logic            vec_take_o,
	output logic [7:0]      vec_addr_o
);
	logic [3:0] cnt_r;

	always_ff @(posedge clk_i) begin
		vec_take_o <= 1'b0;
		// address means nothing outside a take, so keep it moving
		vec_addr_o <= ~vec_addr_o;
		if (rst_i) begin
			cnt_r      <= 4'h0;
			vec_addr_o <= 8'h00;
		end else if (go_i && cnt_r >= dly_i && |irq_req_i[2:0]) begin
			cnt_r      <= 4'h0;
			vec_take_o <= 1'b1;
			vec_addr_o <= irq_req_i[0] ? CIS_VEC_IRQPIN :
				(irq_req_i[1] ? CIS_VEC_TIMER : CIS_VEC_CLKPIN);
		end else if (cnt_r != 4'hf) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule // cis_seq_model
`default_nettype wire

// >>> tb_cis_core.sv
// testbench of the core interrupt status and enable block
// assumes the sequencer model beside it answers vector requests
`timescale 1ns/1ns
`default_nettype none
module tb_cis_core
	import cis_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	cis_wb_req_t req = '0;
	logic        ack, ovf = 1'b0, tpin = 1'b0, xpin = 1'b0, go = 1'b0, vt;
	logic [31:0] dat;
	logic [15:0] pf = 16'h0, pe = 16'h0;
	logic [7:0]  va;
	logic [3:0]  req_o, dly = 4'h2;
	logic        irq;
	int          miscompares = 0, checked = 0;

	always #5 clk_i = ~clk_i;

	cis_core i_cis_core (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(ack),
		.wb_dat_o(dat), .timer_clock_input_pin_i(tpin), .external_irq_pin_i(xpin),
		.timer_overflow_i(ovf), .periph_flags_i(pf), .periph_enables_i(pe),
		.vec_take_i(vt), .vec_addr_i(va), .irq_req_o(req_o), .irq_o(irq));
	cis_seq_model i_cis_seq_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .dly_i(dly),
		.irq_req_i(req_o), .vec_take_o(vt), .vec_addr_o(va));

	task automatic summarize();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// irq_o and irq_req_o judged together
	task automatic chk_sig(input logic [4:0] e);
		#1;
		checked++;
		if ({irq, req_o} !== e) begin
			miscompares++;
			$display("MISMATCH irq expected %h seen %h", e, {irq, req_o});
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		@(posedge clk_i);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: a, dat: {24'h0, wd}};
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (ack === 1'b1)
				break;
		end
		rd = dat[7:0];
		req <= '0;
		if (n == 20) begin
			miscompares++;
			$display("MISMATCH wb_ack expected 1 seen 0");
			summarize();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		wb(1'b1, a, d, x);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] x;
		wb(1'b0, a, 8'h00, x);
		chk8("reg", e, x);
	endtask

	task automatic wait_low(input int b);
		int n;
		for (n = 0; n < 40 && req_o[b] !== 1'b0; n++)
			@(posedge clk_i);
		if (n == 40) begin
			miscompares++;
			$display("MISMATCH irq_req_o expected 0 seen 1");
			summarize();
		end
	endtask

	task automatic pulse_ovf();
		@(posedge clk_i);
		ovf <= 1'b1;
		@(posedge clk_i);
		ovf <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic t_reset();
		rdc(CIS_STATUS_ENABLE_ADR, CIS_STATUS_ENABLE_RST);
		rdc(CIS_CTRL_ADR, 8'h01);
		rdc(8'h40, 8'h00);
	endtask

	task automatic t_timer();
		wr(CIS_CTRL_ADR, 8'h06);
		wr(CIS_STATUS_ENABLE_ADR, 8'h02);
		wr(CIS_EVT_MASK_ADR, 8'h02);
		pulse_ovf();
		chk_sig(5'h12);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h22);
		wr(CIS_EVT_STATUS_ADR, 8'h02);
		repeat (2) @(posedge clk_i);
		chk_sig(5'h02);
		// slow sequencer answer
		dly <= 4'h6;
		go <= 1'b1;
		wait_low(CIS_SRC_TIMER);
		go <= 1'b0;
		rdc(CIS_STATUS_ENABLE_ADR, 8'h02);
	endtask

	task automatic t_gdis();
		wr(CIS_CTRL_ADR, 8'h07);
		pulse_ovf();
		chk_sig(5'h10);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h22);
		wr(CIS_STATUS_ENABLE_ADR, 8'h02);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h02);
		wr(CIS_EVT_STATUS_ADR, 8'h0f);
		wr(CIS_CTRL_ADR, 8'h06);
	endtask

	task automatic t_pins();
		wr(CIS_STATUS_ENABLE_ADR, 8'h05);
		dly <= 4'h2;
		tpin <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk_sig(5'h04);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h45);
		go <= 1'b1;
		wait_low(CIS_SRC_CLKPIN);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h05);
		xpin <= 1'b1;
		// request must be seen up before waiting for the vector to drop it
		repeat (4) @(posedge clk_i);
		chk_sig(5'h01);
		wait_low(CIS_SRC_IRQPIN);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h05);
		go <= 1'b0;
		xpin <= 1'b1;
		wr(CIS_STATUS_ENABLE_ADR, 8'h01);
		xpin <= 1'b0;
		tpin <= 1'b0;
		repeat (8) @(posedge clk_i);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h01);
		xpin <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk_sig(5'h01);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h11);
		// falling edge selected on both pins
		wr(CIS_STATUS_ENABLE_ADR, 8'h01);
		wr(CIS_CTRL_ADR, 8'h00);
		tpin <= 1'b1;
		repeat (8) @(posedge clk_i);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h01);
		tpin <= 1'b0;
		xpin <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk_sig(5'h01);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h51);
	endtask

	task automatic t_periph();
		wr(CIS_STATUS_ENABLE_ADR, 8'h04);
		pf <= 16'h0010;
		repeat (4) @(posedge clk_i);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h04);
		pe <= 16'h0010;
		repeat (4) @(posedge clk_i);
		chk_sig(5'h00);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h84);
		wr(CIS_STATUS_ENABLE_ADR, 8'h08);
		repeat (2) @(posedge clk_i);
		chk_sig(5'h08);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h88);
		pf <= 16'h0000;
		repeat (4) @(posedge clk_i);
		rdc(CIS_STATUS_ENABLE_ADR, 8'h08);
	endtask

	// reset in mid-run with a flag and an event pending
	task automatic t_rst_mid();
		pulse_ovf();
		chk_sig(5'h10);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_sig(5'h00);
		rdc(CIS_STATUS_ENABLE_ADR, CIS_STATUS_ENABLE_RST);
		rdc(CIS_CTRL_ADR, 8'h01);
	endtask

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_timer();
		t_gdis();
		t_pins();
		t_periph();
		t_rst_mid();
		summarize();
	end
endmodule // tb_cis_core
`default_nettype wire
